// File: logic/rtp_pin_sync.sv
`timescale 1ns/10ps
module rtp_pin_sync
	import rtp_pkg::*;
(
	// clock and reset
	input  wire logic              core_clk_in,
	input  wire logic              nrst_in,
	// raw pins
	input  wire logic [SYNC_W-1:0] pins_in,
	// filtered level and rising pulse
	output logic      [SYNC_W-1:0] level_out,
	output logic      [SYNC_W-1:0] rise_out
);
	logic [SYNC_W-1:0] s1_r;
	logic [SYNC_W-1:0] s2_r;
	logic [SYNC_W-1:0] s3_r;
	logic [SYNC_W-1:0] level_r;
	logic [SYNC_W-1:0] rise_r;
	wire  [SYNC_W-1:0] agree;
	wire  [SYNC_W-1:0] level_nxt;
	wire  [SYNC_W-1:0] rise_nxt;

	// a change counts only once stages two and three agree
	assign agree     = ~(s2_r ^ s3_r);
	assign level_nxt = (agree & s3_r) | (~agree & level_r);
	assign rise_nxt  = level_nxt & ~level_r;

	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			s1_r    <= SYNC_RST;
			s2_r    <= SYNC_RST;
			s3_r    <= SYNC_RST;
			level_r <= SYNC_RST;
			rise_r  <= '0;
		end else begin
			s1_r    <= pins_in;
			s2_r    <= s1_r;
			s3_r    <= s2_r;
			level_r <= level_nxt;
			rise_r  <= rise_nxt;
		end
	end

	assign level_out = level_r;
	assign rise_out  = rise_r;
endmodule : rtp_pin_sync

// File: logic/rtp_pkg.sv
package rtp_pkg;
	localparam int unsigned DATA_W      = 8;
	// control pin positions inside the synchroniser vector
	localparam int unsigned CTL_AB_CLK  = 0;
	localparam int unsigned CTL_BA_CLK  = 1;
	localparam int unsigned CTL_AB_CE_N = 2;
	localparam int unsigned CTL_BA_CE_N = 3;
	localparam int unsigned CTL_A_OE_N  = 4;
	localparam int unsigned CTL_B_OE_N  = 5;
	localparam int unsigned CTL_W       = 6;
	// data pin positions inside the synchroniser vector
	localparam int unsigned PIN_A_LSB   = CTL_W;
	localparam int unsigned PIN_B_LSB   = CTL_W + DATA_W;
	localparam int unsigned PIN_PAR     = CTL_W + 2 * DATA_W;
	localparam int unsigned SYNC_W      = PIN_PAR + 1;
	// reset values
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
	localparam logic [SYNC_W-1:0] SYNC_RST = 23'h00003c;
	localparam logic              FLAG_RST = 1'h0;
	localparam logic              PAR_IN_RST = 1'h0;
	localparam logic              PAR_OUT_RST = 1'h1;
	localparam logic              OE_N_RST = 1'h1;
	localparam logic              ERR_N_RST = 1'h1;
endpackage : rtp_pkg

// File: logic/rtp_transceiver.sv
`timescale 1ns/10ps
module rtp_transceiver
	import rtp_pkg::*;
(
	// clock and reset
	input  wire logic              core_clk_in,
	input  wire logic              nrst_in,
	// load controls
	input  wire logic              ab_load_clock_in,
	input  wire logic              ba_load_clock_in,
	input  wire logic              ab_clock_enable_n_in,
	input  wire logic              ba_clock_enable_n_in,
	// output enables
	input  wire logic              a_output_enable_n_in,
	input  wire logic              b_output_enable_n_in,
	// a port pin
	input  wire logic [DATA_W-1:0] a_port_in,
	output logic      [DATA_W-1:0] a_port_out,
	output logic                   a_port_oe_n_out,
	// b port pin
	input  wire logic [DATA_W-1:0] b_port_in,
	output logic      [DATA_W-1:0] b_port_out,
	output logic                   b_port_oe_n_out,
	// parity pin
	input  wire logic              parity_in,
	output logic                   parity_out,
	output logic                   parity_oe_n_out,
	// status
	output logic                   error_n_out,
	output logic                   ab_full_flag_out,
	output logic                   ba_full_flag_out
);
	function automatic logic odd_ones(input logic [DATA_W:0] v);
		odd_ones = ^v;
	endfunction : odd_ones

	logic [SYNC_W-1:0] lvl;
	logic [SYNC_W-1:0] rise;
	logic [DATA_W-1:0] ab_reg_r;
	logic [DATA_W-1:0] ba_reg_r;
	logic              par_reg_r;
	logic              ab_flag_r;
	logic              ba_flag_r;
	logic [DATA_W-1:0] a_out_r;
	logic [DATA_W-1:0] b_out_r;
	logic              a_oe_n_r;
	logic              b_oe_n_r;
	logic              par_out_r;
	logic              err_n_r;

	rtp_pin_sync u_sync (
		.core_clk_in (core_clk_in),
		.nrst_in     (nrst_in),
		.pins_in     ({parity_in, b_port_in, a_port_in, b_output_enable_n_in,
		                a_output_enable_n_in, ba_clock_enable_n_in,
		                ab_clock_enable_n_in, ba_load_clock_in, ab_load_clock_in}),
		.level_out   (lvl),
		.rise_out    (rise)
	);

	// data is synchronised through the same depth as the clocks, so both stay aligned
	wire [DATA_W-1:0] a_pins    = lvl[PIN_A_LSB +: DATA_W];
	wire [DATA_W-1:0] b_pins    = lvl[PIN_B_LSB +: DATA_W];
	wire              par_pin   = lvl[PIN_PAR];
	wire              ab_load   = rise[CTL_AB_CLK] & ~lvl[CTL_AB_CE_N];
	wire              ba_load   = rise[CTL_BA_CLK] & ~lvl[CTL_BA_CE_N];
	wire              ab_clear  = rise[CTL_B_OE_N];
	wire              ba_clear  = rise[CTL_A_OE_N];
	wire              a_oe_n    = lvl[CTL_A_OE_N];
	wire              b_oe_n    = lvl[CTL_B_OE_N];

	// holding registers keep their value unless loaded
	wire [DATA_W-1:0] ab_reg_nxt  = ab_load ? a_pins : ab_reg_r;
	wire [DATA_W-1:0] ba_reg_nxt  = ba_load ? b_pins : ba_reg_r;
	wire              par_reg_nxt = ba_load ? par_pin : par_reg_r;
	// clear beats a simultaneous load, so a lost read never leaves a stale flag
	wire ab_flag_nxt = ab_clear ? 1'h0 : (ab_load ? 1'h1 : ab_flag_r);
	wire ba_flag_nxt = ba_clear ? 1'h0 : (ba_load ? 1'h1 : ba_flag_r);
	// outputs follow the next register value so pins reflect a load one cycle on
	wire [DATA_W-1:0] a_out_nxt = ba_reg_nxt;
	wire [DATA_W-1:0] b_out_nxt = ab_reg_nxt;
	wire              par_out_nxt = ~odd_ones({1'h0, ab_reg_nxt});
	wire              err_n_nxt = a_oe_n | odd_ones({par_reg_nxt, ba_reg_nxt});

	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			ab_reg_r  <= DATA_RST;
			ba_reg_r  <= DATA_RST;
			par_reg_r <= PAR_IN_RST;
			ab_flag_r <= FLAG_RST;
			ba_flag_r <= FLAG_RST;
			a_out_r   <= DATA_RST;
			b_out_r   <= DATA_RST;
			a_oe_n_r  <= OE_N_RST;
			b_oe_n_r  <= OE_N_RST;
			par_out_r <= PAR_OUT_RST;
			err_n_r   <= ERR_N_RST;
		end else begin
			ab_reg_r  <= ab_reg_nxt;
			ba_reg_r  <= ba_reg_nxt;
			par_reg_r <= par_reg_nxt;
			ab_flag_r <= ab_flag_nxt;
			ba_flag_r <= ba_flag_nxt;
			a_out_r   <= a_out_nxt;
			b_out_r   <= b_out_nxt;
			a_oe_n_r  <= a_oe_n;
			b_oe_n_r  <= b_oe_n;
			par_out_r <= par_out_nxt;
			err_n_r   <= err_n_nxt;
		end
	end

	assign a_port_out       = a_out_r;
	assign a_port_oe_n_out  = a_oe_n_r;
	assign b_port_out       = b_out_r;
	assign b_port_oe_n_out  = b_oe_n_r;
	// parity pin shares the b side enable
	assign parity_out       = par_out_r;
	assign parity_oe_n_out  = b_oe_n_r;
	assign error_n_out      = err_n_r;
	assign ab_full_flag_out = ab_flag_r;
	assign ba_full_flag_out = ba_flag_r;

	// checks
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!nrst_in);

	chk_ab_load_data: assert property (
		ab_load |=> ab_reg_r == $past(a_pins))
		else $error("a-to-b register missed a load");
	chk_hold_data: assert property (
		!ab_load && !ba_load |=> $stable(ab_reg_r) && $stable(ba_reg_r) && $stable(par_reg_r))
		else $error("holding register changed without a load");
	chk_ab_flag_set: assert property (
		ab_load && !ab_clear |=> ab_full_flag_out)
		else $error("a-to-b flag not set on load");
	chk_ab_flag_clear: assert property (
		ab_clear |=> !ab_full_flag_out)
		else $error("a-to-b flag not cleared on enable rise");
	chk_ba_flag_clear: assert property (
		ba_clear |=> !ba_full_flag_out)
		else $error("b-to-a flag not cleared on enable rise");
	chk_flag_cause: assert property (
		$rose(ba_full_flag_out) |-> $past(ba_load))
		else $error("b-to-a flag rose without a load");
	chk_b_drive: assert property (
		!b_oe_n |=> !b_port_oe_n_out && b_port_out == ab_reg_r)
		else $error("b port not driven with register data");
	chk_a_disable: assert property (
		a_oe_n |=> a_port_oe_n_out)
		else $error("a port enable not released");
	chk_a_drive: assert property (
		!a_oe_n |=> !a_port_oe_n_out && a_port_out == ba_reg_r)
		else $error("a port not driven with register data");
	chk_parity_gen: assert property (
		!parity_oe_n_out |-> parity_out == ~(^ab_reg_r))
		else $error("generated parity wrong");
	chk_error_check: assert property (
		##1 error_n_out == ($past(a_oe_n) | (^{par_reg_r, ba_reg_r})))
		else $error("error output wrong");
	chk_ba_capture: assert property (
		ba_load |=> ba_reg_r == $past(b_pins) && par_reg_r == $past(par_pin))
		else $error("b-to-a capture wrong");

	// event checks look one cycle on, since outputs follow the registered next value
	chk_ba_flag_set: assert property (
		ba_load && !ba_clear |=> ba_full_flag_out)
		else $error("b-to-a flag not set on load");
	chk_ab_flag_cause: assert property (
		$rose(ab_full_flag_out) |-> $past(ab_load))
		else $error("a-to-b flag rose without a load");
	chk_ab_flag_hold: assert property (
		!ab_load && !ab_clear |=> $stable(ab_full_flag_out))
		else $error("a-to-b flag changed with no event");
	chk_ba_flag_hold: assert property (
		!ba_load && !ba_clear |=> $stable(ba_full_flag_out))
		else $error("b-to-a flag changed with no event");
	chk_b_disable: assert property (
		b_oe_n |=> b_port_oe_n_out && parity_oe_n_out)
		else $error("b port or parity enable not released");
	chk_b_data_load: assert property (
		ab_load |=> b_port_out == $past(a_pins))
		else $error("b port data missed a load");
	chk_a_data_load: assert property (
		ba_load |=> a_port_out == $past(b_pins))
		else $error("a port data missed a load");
	chk_parity_load: assert property (
		ab_load |=> parity_out == ~(^$past(a_pins)))
		else $error("parity not updated with a load");
	chk_error_load: assert property (
		ba_load && !a_oe_n |=> error_n_out == (^{$past(par_pin), $past(b_pins)}))
		else $error("error output not updated with a load");
	chk_error_idle: assert property (
		a_port_oe_n_out |-> error_n_out)
		else $error("error output low while a port disabled");
	chk_ab_ce_block: assert property (
		rise[CTL_AB_CLK] && lvl[CTL_AB_CE_N] |=> $stable(ab_reg_r))
		else $error("a-to-b register loaded with enable high");
	chk_ba_ce_block: assert property (
		rise[CTL_BA_CLK] && lvl[CTL_BA_CE_N] |=> $stable(ba_reg_r) && $stable(par_reg_r))
		else $error("b-to-a register loaded with enable high");

	// the collision cover needs a crafted race between load and read release
	cov_ab_load: cover property (ab_load ##[1:200] ab_clear);
	cov_ba_load: cover property (ba_load ##[1:200] ba_clear);
	cov_error: cover property (!a_oe_n && !err_n_nxt);
	cov_collide: cover property (ab_load && ab_clear);
	cov_refused: cover property (rise[CTL_AB_CLK] && lvl[CTL_AB_CE_N]);
endmodule : rtp_transceiver

// File: verif/rtp_bus_partner.sv
`timescale 1ns/10ps
module rtp_bus_partner
	import rtp_pkg::*;
(
	// clock and flags seen
	input  wire logic              clk_in,
	input  wire logic              ab_full_in,
	input  wire logic              ba_full_in,
	// pins driven
	output logic                   ab_clk_out,
	output logic                   ba_clk_out,
	output logic                   ab_ce_n_out,
	output logic                   ba_ce_n_out,
	output logic                   a_oe_n_out,
	output logic                   b_oe_n_out,
	output logic      [DATA_W-1:0] a_drv_out,
	output logic      [DATA_W-1:0] b_drv_out,
	output logic                   par_drv_out
);
	initial begin
		{ab_clk_out, ba_clk_out, a_drv_out, b_drv_out, par_drv_out} = 'h0;
		{ab_ce_n_out, ba_ce_n_out, a_oe_n_out, b_oe_n_out} = 4'hf;
	end
	// sender: enable low qualifies the load edge, held well around the rise
	task automatic send(input logic ba, input logic [DATA_W-1:0] d, input logic p,
		input logic ce_n);
		int n;
		for (n = 0; n < 40 && (ba ? ba_full_in : ab_full_in); n++) @(posedge clk_in);
		@(posedge clk_in);
		if (ba) begin
			b_drv_out <= d;
			par_drv_out <= p;
			ba_ce_n_out <= ce_n;
		end else begin
			a_drv_out <= d;
			ab_ce_n_out <= ce_n;
		end
		repeat (3) @(posedge clk_in);
		if (ba) ba_clk_out <= 1'h1; else ab_clk_out <= 1'h1;
		repeat (4) @(posedge clk_in);
		ab_clk_out <= 1'h0;
		ba_clk_out <= 1'h0;
		repeat (3) @(posedge clk_in);
		// bus released: show the inverse so stale data cannot pass by luck
		{ab_ce_n_out, ba_ce_n_out} <= 2'h3;
		a_drv_out <= ~a_drv_out;
		b_drv_out <= ~b_drv_out;
		par_drv_out <= ~par_drv_out;
	endtask : send
	// receiver: output enable low to read, rise to release
	task automatic oe(input logic ba, input logic v);
		@(posedge clk_in);
		if (ba) a_oe_n_out <= v; else b_oe_n_out <= v;
	endtask : oe
endmodule : rtp_bus_partner

// File: verif/testbench.sv
`timescale 1ns/10ps
module testbench;
	import rtp_pkg::*;
	logic              clk, nrst_in, abc, bac, abe, bae, aoe, boe, pd, po, pon, eon, abf, baf;
	logic              aon, bon;
	logic [DATA_W-1:0] ad, bd, ao, bo;
	int                failures, n_tests, cyc;
	// wire level: the device wins while it drives
	wire [DATA_W-1:0] a_w = aon ? ad : ao;
	wire [DATA_W-1:0] b_w = bon ? bd : bo;
	wire              p_w = pon ? pd : po;
	rtp_transceiver i_rtp_transceiver (.core_clk_in(clk), .nrst_in(nrst_in),
		.ab_load_clock_in(abc), .ba_load_clock_in(bac), .ab_clock_enable_n_in(abe),
		.ba_clock_enable_n_in(bae), .a_output_enable_n_in(aoe), .b_output_enable_n_in(boe),
		.a_port_in(a_w), .a_port_out(ao), .a_port_oe_n_out(aon), .b_port_in(b_w),
		.b_port_out(bo), .b_port_oe_n_out(bon), .parity_in(p_w), .parity_out(po),
		.parity_oe_n_out(pon), .error_n_out(eon), .ab_full_flag_out(abf),
		.ba_full_flag_out(baf));
	rtp_bus_partner i_rtp_bus_partner (.clk_in(clk), .ab_full_in(abf), .ba_full_in(baf),
		.ab_clk_out(abc), .ba_clk_out(bac), .ab_ce_n_out(abe), .ba_ce_n_out(bae),
		.a_oe_n_out(aoe), .b_oe_n_out(boe), .a_drv_out(ad), .b_drv_out(bd), .par_drv_out(pd));
	task automatic test_done;
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : test_done
	task automatic check(input string what, input logic [DATA_W-1:0] exp,
		input logic [DATA_W-1:0] got);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// bounded wait; the pin pipeline takes about five cycles
	task automatic wait_for(input logic ba, input logic v);
		int n;
		for (n = 0; n < 12 && ((ba ? baf : abf) !== v); n++) @(posedge clk);
		#1;
	endtask : wait_for
	task automatic t_hold(input logic [DATA_W-1:0] prev);
		i_rtp_bus_partner.send(1'h0, ~prev, 1'h0, 1'h1);
		repeat (8) @(posedge clk);
		check("ab flag", 8'(1'h0), 8'(abf));
		check("ab data", prev, bo);
	endtask : t_hold
	task automatic t_ab(input logic [DATA_W-1:0] d);
		i_rtp_bus_partner.send(1'h0, d, 1'h0, 1'h0);
		wait_for(1'h0, 1'h1);
		check("ab flag set", 8'(1'h1), 8'(abf));
		check("ab data", d, bo);
		check("b oe idle", 8'(1'h1), 8'({bon, pon} == 2'h3));
		i_rtp_bus_partner.oe(1'h0, 1'h0);
		repeat (7) @(posedge clk);
		check("b oe", 8'(1'h0), 8'(bon | pon));
		check("parity", 8'(~^d), 8'(po));
		i_rtp_bus_partner.oe(1'h0, 1'h1);
		wait_for(1'h0, 1'h0);
		check("ab flag clr", 8'(1'h0), 8'(abf));
		repeat (2) @(posedge clk);
		check("b oe off", 8'(1'h1), 8'(bon & pon));
	endtask : t_ab
	task automatic t_ba(input logic [DATA_W-1:0] d, input logic p);
		i_rtp_bus_partner.send(1'h1, d, p, 1'h0);
		wait_for(1'h1, 1'h1);
		check("ba flag set", 8'(1'h1), 8'(baf));
		check("ba data", d, ao);
		check("err idle", 8'(1'h1), 8'(eon));
		i_rtp_bus_partner.oe(1'h1, 1'h0);
		repeat (7) @(posedge clk);
		check("a oe", 8'(1'h0), 8'(aon));
		check("err", 8'(^{d, p}), 8'(eon));
		i_rtp_bus_partner.oe(1'h1, 1'h1);
		wait_for(1'h1, 1'h0);
		check("ba flag clr", 8'(1'h0), 8'(baf));
		check("ab kept", 8'hff, bo);
	endtask : t_ba
	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end
	// run ceiling well above the nine transfers and two refused sends made here
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			failures++;
			test_done;
		end
	end
	initial begin
		{failures, n_tests, cyc} = '0;
		nrst_in = 1'h0;
		repeat (16) @(posedge clk);
		nrst_in <= 1'h1;
		t_hold(8'h00);
		t_ab(8'h00);
		t_ab(8'h01);
		t_ab(8'ha5);
		t_ab(8'hff);
		t_hold(8'hff);
		t_ba(8'h00, 1'h1);
		t_ba(8'h00, 1'h0);
		t_ba(8'h81, 1'h1);
		t_ba(8'h7e, 1'h1);
		t_ba(8'h3c, 1'h0);
		test_done;
	end
endmodule : testbench
